//--- hdl/timer_compare_core.sv
// 8-bit timer with compare outputs, pin override and prescaler reset control
//
// Function
// [R1] A new output action takes effect at the first compare match after it.
// [R2] Action field zero leaves the output compare state unchanged on match.
// [R3] Force strobe in non-PWM modes applies the action immediately.
// [R4] Reset clears the output compare state.
// [R5] Nonzero action field puts compare state on the pin instead of port value.
// [R6] Pin drives only while direction selects output, whatever the mode.
// [R7] Output compare state survives changes of waveform mode.
// [R8] Three waveform bits across controls A and B choose the count sequence.
// [R9] Action field picks inverted/non-inverted PWM, or set/clear/toggle otherwise.
// [R10] Normal mode only counts up and wraps from max to zero.
// [R11] Overflow flag sets as count becomes zero; counting never clears it.
// [R12] Taking the overflow interrupt clears the overflow flag.
// [R13] Count register accepts software writes at any time in normal mode.
// [R14] Clear-on-match mode clears the count on match with compare A.
// [R15] Hold mode set keeps both prescaler reset bits as written.
// [R16] Hold mode cleared makes hardware clear both prescaler reset bits.
// [R17] Async prescaler reset self-clears, or holds while busy or hold mode.
// [R18] Sync prescaler reset hits the shared prescaler, self-clears unless hold.
// [R19] Software should not write count equal to compare or bottom downcounting.
// [R20] Software should set up compare state before enabling pin output.
// [R21] Control register sits at its data offset and offset minus 0x20.
// [R22] A count write blocks compare matches in the next timer tick.
// [R23] Forced compare sets no flag and leaves the counter alone.
// [R24] Every compare match sets its flag, which may request an interrupt.
`timescale 1ns/10ps
`include "timer_params.svh"
module timer_compare_core #(
  parameter int PRESCALE_WIDTH = `PRESCALE_BITS
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_io_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] port_out_val,
  input wire logic [1:0] port_dir_out,
  input wire logic async_clock_mode,
  input wire logic async_reset_busy,
  input wire logic ovf_int_ack,
  input wire logic [1:0] cmp_int_ack,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic ovf_irq,
  output logic [1:0] cmp_irq,
  output logic async_prescaler_reset_req,
  output logic sync_prescaler_reset_req,
  output timer_pkg::waveform_select_t wave_mode
);
  import timer_pkg::*;

  if (PRESCALE_WIDTH < 10) begin : g_check
    $error("PRESCALE_WIDTH must be at least 10");
  end

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic [7:0] eff_addr(input logic [7:0] a, input logic io);
    eff_addr = io ? 8'(a + `IO_SPACE_OFFSET) : a;
  endfunction

  logic [7:0] addr;
  logic wr_gtc, wr_ca, wr_cb, wr_cc, wr_cnt, wr_cmp_a, wr_cmp_b, wr_flag, wr_mask;

  assign addr = eff_addr(reg_addr, reg_io_space); // [R21]
  assign wr_gtc = reg_wr && (addr == `OFF_SYNC_PRESCALER_CTRL); // [R21]
  assign wr_ca = reg_wr && (addr == `OFF_TIMER_CONTROL_A);
  assign wr_cb = reg_wr && (addr == `OFF_TIMER_CONTROL_B);
  assign wr_cc = reg_wr && (addr == `OFF_TIMER_CONTROL_C);
  assign wr_cnt = reg_wr && (addr == `OFF_COUNT_VALUE);
  assign wr_cmp_a = reg_wr && (addr == `OFF_COMPARE_VALUE_A);
  assign wr_cmp_b = reg_wr && (addr == `OFF_COMPARE_VALUE_B);
  assign wr_flag = reg_wr && (addr == `OFF_FLAG_REG);
  assign wr_mask = reg_wr && (addr == `OFF_MASK_REG);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] timer_control_a;
  logic [7:0] timer_control_b;
  logic [7:0] count_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [2:0] flag_reg;
  logic [2:0] mask_reg;
  logic sync_hold_mode, async_prescaler_reset, sync_prescaler_reset, count_down, block_match;
  logic [PRESCALE_WIDTH-1:0] presc_cnt;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_control_a <= `RST_REG;
      timer_control_b <= `RST_REG;
      compare_value_a <= `RST_REG;
      compare_value_b <= `RST_REG;
      mask_reg <= 3'h0;
    end else begin
      if (wr_ca) timer_control_a <= reg_wdata;
      if (wr_cb) timer_control_b <= reg_wdata;
      if (wr_cmp_a) compare_value_a <= reg_wdata;
      if (wr_cmp_b) compare_value_b <= reg_wdata;
      if (wr_mask) mask_reg <= reg_wdata[2:0];
    end
  end

  // --------------------------------------------------------------------------
  // Prescaler reset control
  // --------------------------------------------------------------------------
  logic [2:0] busy_sync;
  logic busy_level, next_hold, next_async_prs, next_sync_prs, sync_reset_now, async_reset_now;

  // Busy comes from the asynchronous timer's clock domain
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_sync <= 3'h0;
      busy_level <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[1:0], async_reset_busy};
      if (busy_sync[1] == busy_sync[2]) busy_level <= busy_sync[2];
    end
  end

  assign next_hold = wr_gtc ? reg_wdata[`BIT_SYNC_HOLD_MODE] : sync_hold_mode;
  // Hold mode keeps what was written; otherwise the bit self-clears [R15] [R16] [R18]
  assign next_sync_prs = next_hold &&
                         (wr_gtc ? reg_wdata[`BIT_SYNC_PRESCALER_RESET] : sync_prescaler_reset);
  // In async clock mode the async bit also lingers while the far prescaler reports its reset in progress [R17]
  assign next_async_prs = wr_gtc ?
      (reg_wdata[`BIT_ASYNC_PRESCALER_RESET] && (next_hold || async_clock_mode)) :
      (async_prescaler_reset && (sync_hold_mode || (async_clock_mode && busy_level)));
  assign sync_reset_now = sync_prescaler_reset ||
                          (wr_gtc && reg_wdata[`BIT_SYNC_PRESCALER_RESET]); // [R18]
  assign async_reset_now = async_prescaler_reset ||
                           (wr_gtc && reg_wdata[`BIT_ASYNC_PRESCALER_RESET]); // [R17]

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_hold_mode <= 1'b0;
      sync_prescaler_reset <= 1'b0;
      async_prescaler_reset <= 1'b0;
      sync_prescaler_reset_req <= 1'b0;
      async_prescaler_reset_req <= 1'b0;
    end else begin
      sync_hold_mode <= next_hold;
      sync_prescaler_reset <= next_sync_prs; // [R15] [R16]
      async_prescaler_reset <= next_async_prs; // [R16] [R17]
      sync_prescaler_reset_req <= sync_reset_now;
      async_prescaler_reset_req <= async_reset_now;
    end
  end

  // --------------------------------------------------------------------------
  // Prescaler and timer tick
  // --------------------------------------------------------------------------
  clock_select_t clk_sel;
  logic tick;

  assign clk_sel = clock_select_t'(timer_control_b[2:0]);
  // External clock inputs are not part of this block; those selects stop the timer
  assign tick = !sync_reset_now && (
      (clk_sel == CLK_DIV1) ||
      (clk_sel == CLK_DIV8 && (&presc_cnt[2:0])) ||
      (clk_sel == CLK_DIV64 && (&presc_cnt[5:0])) ||
      (clk_sel == CLK_DIV256 && (&presc_cnt[7:0])) ||
      (clk_sel == CLK_DIV1024 && (&presc_cnt[9:0])));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_cnt <= '0;
    end else begin
      presc_cnt <= sync_reset_now ? '0 : presc_cnt + 1'b1; // [R18]
    end
  end

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  logic mode_fast, mode_phase, at_top, next_down, ovf_event;
  logic [7:0] top;
  logic [7:0] next_count;
  logic [1:0] match;
  waveform_select_t wave_mode_next;

  // Only the waveform bits shape the sequence [R8]
  assign wave_mode_next = waveform_select_t'({timer_control_b[`BIT_WAVE_HI_B],
                                              timer_control_a[1:0]});
  assign mode_fast = (wave_mode_next == WAVE_FAST_FF) || (wave_mode_next == WAVE_FAST_A);
  assign mode_phase = (wave_mode_next == WAVE_PHASE_FF) || (wave_mode_next == WAVE_PHASE_A);
  assign top = (wave_mode_next == WAVE_CLEAR_ON_MATCH || wave_mode_next == WAVE_PHASE_A ||
                wave_mode_next == WAVE_FAST_A) ? compare_value_a : `COUNT_MAX; // [R14]
  assign at_top = (count_value == top);

  always_comb begin
    next_count = count_value;
    next_down = count_down;
    if (wr_cnt) begin
      next_count = reg_wdata; // [R13]
    end else if (tick && mode_phase) begin
      if (!count_down && at_top) begin
        next_down = 1'b1;
        next_count = 8'(count_value - 1'b1);
      end else if (count_down && count_value == `COUNT_BOTTOM) begin
        next_down = 1'b0;
        next_count = 8'(count_value + 1'b1);
      end else begin
        next_count = count_down ? 8'(count_value - 1'b1) : 8'(count_value + 1'b1);
      end
    end else if (tick) begin
      next_down = 1'b0;
      // Normal mode: top is max, so this is a plain wrap [R10] [R14]
      next_count = at_top ? `COUNT_BOTTOM : 8'(count_value + 1'b1);
    end
  end

  // Overflow as the count reaches bottom (max->0 in normal and clear-on-match) [R11]
  assign ovf_event = tick && !wr_cnt && (mode_phase ?
      (count_down && count_value == `COUNT_BOTTOM) :
      (wave_mode_next == WAVE_CLEAR_ON_MATCH ? count_value == `COUNT_MAX : at_top));
  assign match[0] = tick && !block_match && (count_value == compare_value_a); // [R22]
  assign match[1] = tick && !block_match && (count_value == compare_value_b); // [R22]

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_value <= `COUNT_BOTTOM;
      count_down <= 1'b0;
      block_match <= 1'b0;
      wave_mode <= WAVE_NORMAL;
    end else begin
      count_value <= next_count;
      count_down <= next_down;
      // Held until a tick passes, even with the clock stopped [R22]
      block_match <= wr_cnt || (block_match && !tick);
      wave_mode <= wave_mode_next;
    end
  end

  // --------------------------------------------------------------------------
  // Flags and interrupt requests
  // --------------------------------------------------------------------------
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign flag_set = {match, ovf_event}; // [R11] [R24]
  assign flag_clr = (wr_flag ? reg_wdata[2:0] : 3'h0) |
                    {cmp_int_ack, ovf_int_ack}; // [R12]

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= 3'h0;
      ovf_irq <= 1'b0;
      cmp_irq <= 2'h0;
    end else begin
      // A set in the same cycle as a clear wins
      flag_reg <= flag_set | (flag_reg & ~flag_clr); // [R12] [R24]
      ovf_irq <= flag_reg[`BIT_OVERFLOW] && mask_reg[`BIT_OVERFLOW] && !ovf_int_ack;
      cmp_irq <= flag_reg[2:1] & mask_reg[2:1] & ~cmp_int_ack; // [R24]
    end
  end

  // --------------------------------------------------------------------------
  // Compare output units and pin override
  // --------------------------------------------------------------------------
  logic [1:0] compare_output_state;
  logic [1:0] override;

  for (genvar g = 0; g < 2; g++) begin : g_unit
    compare_unit_if u_if();
    assign u_if.match = match[g];
    // Force never reaches the flags or the counter [R3] [R23]
    assign u_if.force_hit = wr_cc && reg_wdata[`BIT_FORCE_A-g];
    // Action read live, so a new field counts from the next match [R1]
    assign u_if.action = action_t'(timer_control_a[`BIT_ACTION_A_HI-2*g -: 2]);
    assign u_if.mode_fast = mode_fast;
    assign u_if.mode_phase = mode_phase;
    assign u_if.toggle_ok = (g == 0) && timer_control_b[`BIT_WAVE_HI_B];
    assign u_if.count_down = count_down;
    assign u_if.bottom_hit = tick && !wr_cnt && at_top;
    assign compare_output_state[g] = u_if.state;
    assign override[g] = |timer_control_a[`BIT_ACTION_A_HI-2*g -: 2]; // [R5]

    compare_output_unit u_unit (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .bus(u_if.unit)
    );
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= 2'h0;
      pin_oe <= 2'h0;
    end else begin
      // Mode plays no part in the override [R5] [R6]
      pin_out <= (override & compare_output_state) | (~override & port_out_val);
      pin_oe <= port_dir_out; // [R6]
    end
  end

  // --------------------------------------------------------------------------
  // Read path; unmapped addresses and control C read as zero
  // --------------------------------------------------------------------------
  logic [7:0] read_mux;

  assign read_mux =
      (addr == `OFF_SYNC_PRESCALER_CTRL) ? {sync_hold_mode, 5'h00, async_prescaler_reset,
                                             sync_prescaler_reset} :
      (addr == `OFF_TIMER_CONTROL_A) ? timer_control_a :
      (addr == `OFF_TIMER_CONTROL_B) ? timer_control_b :
      (addr == `OFF_COUNT_VALUE) ? count_value :
      (addr == `OFF_COMPARE_VALUE_A) ? compare_value_a :
      (addr == `OFF_COMPARE_VALUE_B) ? compare_value_b :
      (addr == `OFF_FLAG_REG) ? {5'h00, flag_reg} :
      (addr == `OFF_MASK_REG) ? {5'h00, mask_reg} : 8'h00;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
    end
  end
endmodule

//--- shared/timer_params.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (data space)
// ----------------------------------------------------------------------------
`define IO_SPACE_OFFSET 8'h20
`define OFF_SYNC_PRESCALER_CTRL 8'h43
`define OFF_TIMER_CONTROL_A 8'h44
`define OFF_TIMER_CONTROL_B 8'h45
`define OFF_COUNT_VALUE 8'h46
`define OFF_COMPARE_VALUE_A 8'h47
`define OFF_COMPARE_VALUE_B 8'h48
`define OFF_TIMER_CONTROL_C 8'h49
`define OFF_FLAG_REG 8'h35
`define OFF_MASK_REG 8'h6e

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_SYNC_HOLD_MODE 7
`define BIT_ASYNC_PRESCALER_RESET 1
`define BIT_SYNC_PRESCALER_RESET 0
`define BIT_ACTION_A_HI 7
`define BIT_ACTION_B_HI 5
`define BIT_WAVE_HI_B 3
`define BIT_FORCE_A 7
`define BIT_OVERFLOW 0

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define RST_REG 8'h00
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`define PRESCALE_BITS 10

`endif

//--- shared/timer_pkg.sv
// Types shared by the timer core and its compare output units
package timer_pkg;

  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'b000,
    WAVE_PHASE_FF = 3'b001,
    WAVE_CLEAR_ON_MATCH = 3'b010,
    WAVE_FAST_FF = 3'b011,
    WAVE_RESERVED4 = 3'b100,
    WAVE_PHASE_A = 3'b101,
    WAVE_RESERVED6 = 3'b110,
    WAVE_FAST_A = 3'b111
  } waveform_select_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR = 2'b10,
    ACT_SET = 2'b11
  } action_t;

  typedef enum logic [2:0] {
    CLK_STOP = 3'b000,
    CLK_DIV1 = 3'b001,
    CLK_DIV8 = 3'b010,
    CLK_DIV64 = 3'b011,
    CLK_DIV256 = 3'b100,
    CLK_DIV1024 = 3'b101,
    CLK_EXT_FALL = 3'b110,
    CLK_EXT_RISE = 3'b111
  } clock_select_t;

endpackage

//--- shared/compare_unit_if.sv
// Signals between the timer core and one compare output unit
`timescale 1ns/10ps
interface compare_unit_if;
  import timer_pkg::*;
  logic match;
  logic force_hit;
  action_t action;
  logic mode_fast;
  logic mode_phase;
  logic toggle_ok;
  logic count_down;
  logic bottom_hit;
  logic state;

  modport core (output match, force_hit, action, mode_fast, mode_phase, toggle_ok,
                output count_down, bottom_hit, input state);
  modport unit (input match, force_hit, action, mode_fast, mode_phase, toggle_ok,
                input count_down, bottom_hit, output state);
endinterface

//--- hdl/compare_output_unit.sv
// Compare output state of one channel, updated on match, force or bottom
`timescale 1ns/10ps
module compare_output_unit (
  input wire logic sys_clk,
  input wire logic arst_n,
  compare_unit_if.unit bus
);
  import timer_pkg::*;

  logic next_state, toggled, plain_action, pwm;

  // --------------------------------------------------------------------------
  // Action selection
  // --------------------------------------------------------------------------
  assign toggled = ~bus.state;
  assign pwm = bus.mode_fast | bus.mode_phase;
  // Non-PWM action: set, clear or toggle as the action field says [R9]
  assign plain_action = (bus.action == ACT_TOGGLE) ? toggled :
                        (bus.action == ACT_SET);

  always_comb begin
    next_state = bus.state;
    if (bus.action == ACT_NONE) begin
      next_state = bus.state; // [R2]
    end else if (bus.force_hit && !pwm) begin
      next_state = plain_action; // [R3] [R23]
    end else if (bus.match && !pwm) begin
      next_state = plain_action; // [R1] [R9]
    end else if (bus.match && bus.mode_fast) begin
      case (bus.action)
        ACT_TOGGLE: next_state = bus.toggle_ok ? toggled : bus.state;
        ACT_CLEAR: next_state = 1'b0; // [R9]
        ACT_SET: next_state = 1'b1; // [R9]
        default: next_state = bus.state;
      endcase
    end else if (bus.match && bus.mode_phase) begin
      case (bus.action)
        ACT_TOGGLE: next_state = bus.toggle_ok ? toggled : bus.state;
        ACT_CLEAR: next_state = bus.count_down; // [R9]
        ACT_SET: next_state = ~bus.count_down; // [R9]
        default: next_state = bus.state;
      endcase
    end else if (bus.bottom_hit && bus.mode_fast) begin
      case (bus.action)
        ACT_CLEAR: next_state = 1'b1;
        ACT_SET: next_state = 1'b0;
        default: next_state = bus.state;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State flop; mode changes never touch it
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.state <= 1'b0; // [R4]
    end else begin
      bus.state <= next_state; // [R7]
    end
  end
endmodule

//--- tb/timer_compare_core_properties.sv
// Port checker of the timer compare core
`timescale 1ns/10ps
module timer_compare_core_properties #(
  parameter int PRESCALE_WIDTH = 10
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_io_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] port_dir_out,
  input wire logic ovf_int_ack,
  input wire logic [1:0] pin_oe,
  input wire logic ovf_irq,
  input wire logic async_prescaler_reset_req,
  input wire logic sync_prescaler_reset_req,
  input wire timer_pkg::waveform_select_t wave_mode
);
  import timer_pkg::*;
  // ------------------------------
  // Decoding
  // ------------------------------
  wire ctrl_sel = reg_io_space ? (reg_addr == 8'h23) : (reg_addr == 8'h43);
  wire ctrl_wr = reg_wr && ctrl_sel;
  wire ctl_a_wr = reg_wr && !reg_io_space && (reg_addr == 8'h44);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence hold_wr; ctrl_wr && reg_wdata[7] && reg_wdata[0]; endsequence
  sequence pulse_wr; ctrl_wr && !reg_wdata[7] && reg_wdata[0]; endsequence
  sequence free_wr; ctrl_wr && !reg_wdata[7]; endsequence
  sequence quiet3; !reg_wr [*3]; endsequence
  // ------------------------------
  // Properties
  // ------------------------------
  a_sync_pulse_rise: assert property (pulse_wr |-> ##[1:2] sync_prescaler_reset_req)
    else $error("sync prescaler reset not requested after write");
  a_hold_keeps_req: assert property (hold_wr ##1 quiet3 |-> sync_prescaler_reset_req)
    else $error("sync prescaler reset dropped while hold mode set");
  a_release_clears: assert property (free_wr ##1 quiet3 |-> !sync_prescaler_reset_req)
    else $error("sync prescaler reset still high after release");
  a_async_req_clears: assert property (free_wr ##0 !reg_wdata[1] ##1 quiet3
    |-> !async_prescaler_reset_req)
    else $error("async prescaler reset still high after release");
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_ctrl_spare_zero: assert property (reg_rd && ctrl_sel |=> reg_rdata[6:2] == 5'h00)
    else $error("spare control bits read nonzero");
  a_ovf_ack_clears: assert property (ovf_int_ack |=> !ovf_irq)
    else $error("overflow request stays after acknowledge");
  a_dir_to_oe: assert property (1'b1 |=> pin_oe == $past(port_dir_out))
    else $error("pin enable does not follow direction");
  a_wave_low_bits: assert property (ctl_a_wr ##1 !reg_wr [*2]
    |-> wave_mode[1:0] == $past(reg_wdata[1:0], 2))
    else $error("waveform select low bits not taken from control a");
endmodule

//--- tb/cpu_port_model.sv
// Processor register access and port pin model facing the timer
`timescale 1ns/10ps
module cpu_port_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_io_space,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  output logic [1:0] port_out_val,
  output logic [1:0] port_dir_out,
  output logic async_clock_mode,
  output logic async_reset_busy,
  output logic ovf_int_ack,
  output logic [1:0] cmp_int_ack
);
  initial begin
    {reg_addr, reg_io_space, reg_wr, reg_rd, reg_wdata} = '0;
    {port_out_val, port_dir_out, async_clock_mode, async_reset_busy} = '0;
    {ovf_int_ack, cmp_int_ack} = '0;
  end
  // Software never writes the count equal to a live compare value
  // Released data lines carry the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_io_space <= io;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, input logic io, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_io_space <= io;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

//--- tb/timer_compare_output_modes_bench.sv
// Self-checking bench of the timer compare core
`timescale 1ns/10ps
module timer_compare_output_modes_bench;
  import timer_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_io_space, reg_wr, reg_rd, async_clock_mode, async_reset_busy, ovf_int_ack, ovf_irq;
  logic [1:0] port_out_val, port_dir_out, cmp_int_ack, pin_out, pin_oe, cmp_irq;
  logic async_prescaler_reset_req, sync_prescaler_reset_req, pv;
  waveform_select_t wave_mode;
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] acts [5] = '{8'hc0, 8'h80, 8'h40, 8'h40, 8'h00};
  logic [4:0] exps = 5'h15;
  always #5 sys_clk = ~sys_clk;
  timer_compare_core dut_u (.sys_clk, .arst_n, .reg_addr, .reg_io_space, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .port_out_val, .port_dir_out, .async_clock_mode, .async_reset_busy,
    .ovf_int_ack, .cmp_int_ack, .pin_out, .pin_oe, .ovf_irq, .cmp_irq,
    .async_prescaler_reset_req, .sync_prescaler_reset_req, .wave_mode);
  cpu_port_model cpu_u (.sys_clk, .reg_rdata, .reg_addr, .reg_io_space, .reg_wr, .reg_rd,
    .reg_wdata, .port_out_val, .port_dir_out, .async_clock_mode, .async_reset_busy,
    .ovf_int_ack, .cmp_int_ack);
  // ------------------------------
  // Checking helpers
  // ------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      input logic io = 1'b0);
    cpu_u.rd(a, io, d);
    chk($sformatf("register %h", a), d & m, e);
  endtask
  // Pin is registered after the state, so allow three cycles
  task automatic pin_chk(input logic e);
    repeat (3) @(negedge sys_clk);
    chk("pin_out", {7'h00, pin_out[0]}, {7'h00, e});
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    rchk(8'h43, 8'hff, 8'h00);
    cpu_u.wr(8'h43, 8'h01);
    rchk(8'h43, 8'h01, 8'h00);
    cpu_u.wr(8'h43, 8'h83);
    rchk(8'h23, 8'h83, 8'h83, 1'h1);
    cpu_u.wr(8'h23, 8'h00, 1'h1);
    rchk(8'h43, 8'h83, 8'h00);
    @(posedge sys_clk);
    cpu_u.async_clock_mode <= 1'b1;
    cpu_u.async_reset_busy <= 1'b1;
    repeat (3) @(posedge sys_clk); // Busy must pass the synchroniser before the write
    cpu_u.wr(8'h43, 8'h02);
    rchk(8'h43, 8'h02, 8'h02);
    @(posedge sys_clk);
    cpu_u.async_reset_busy <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rchk(8'h43, 8'h02, 8'h00);
    $display("prescaler test done");
    // Compare state is set up by force before the pin is driven
    @(posedge sys_clk);
    cpu_u.port_out_val <= 2'b01;
    cpu_u.wr(8'h44, 8'h40);
    pin_chk(1'b0);
    chk("pin_oe", {6'h00, pin_oe}, 8'h00);
    cpu_u.wr(8'h35, 8'h07);
    cpu_u.wr(8'h46, 8'h33);
    for (int i = 0; i < 5; i++) begin
      cpu_u.wr(8'h44, acts[i]);
      cpu_u.wr(8'h49, 8'h80);
      pin_chk(exps[i]);
    end
    cpu_u.wr(8'h44, 8'h40);
    pin_chk(1'b0);
    rchk(8'h46, 8'hff, 8'h33);
    rchk(8'h35, 8'h02, 8'h00);
    @(posedge sys_clk);
    cpu_u.port_dir_out <= 2'b01;
    cpu_u.wr(8'h44, 8'hc0);
    cpu_u.wr(8'h49, 8'h80);
    cpu_u.wr(8'h44, 8'hc2);
    pin_chk(1'b1);
    chk("pin_oe", {6'h00, pin_oe}, 8'h01);
    chk("wave_mode", {5'h00, wave_mode}, {5'h00, WAVE_CLEAR_ON_MATCH});
    $display("force test done");
    cpu_u.wr(8'h44, 8'h42);
    cpu_u.wr(8'h6e, 8'h02);
    cpu_u.wr(8'h47, 8'h04);
    cpu_u.wr(8'h46, 8'h00);
    cpu_u.wr(8'h45, 8'h01);
    for (int i = 0; i < 6; i++) begin
      cpu_u.rd(8'h46, 1'b0, d);
      chk("count_top", {7'h00, d <= 8'h04}, 8'h01);
    end
    rchk(8'h35, 8'h02, 8'h02);
    chk("cmp_irq", {6'h00, cmp_irq}, 8'h01);
    @(negedge sys_clk);
    pv = pin_out[0];
    repeat (5) @(negedge sys_clk);
    chk("toggle", {7'h00, pin_out[0]}, {7'h00, ~pv});
    cpu_u.wr(8'h45, 8'h00);
    $display("clear on match test done");
    // Clock stopped before the ack so no new overflow can race it
    cpu_u.wr(8'h44, 8'h00);
    cpu_u.wr(8'h6e, 8'h01);
    cpu_u.wr(8'h35, 8'h07);
    cpu_u.wr(8'h46, 8'hff);
    cpu_u.wr(8'h45, 8'h01);
    rchk(8'h35, 8'h01, 8'h01);
    cpu_u.wr(8'h45, 8'h00);
    chk("ovf_irq", {7'h00, ovf_irq}, 8'h01);
    @(posedge sys_clk);
    cpu_u.ovf_int_ack <= 1'b1;
    @(posedge sys_clk);
    cpu_u.ovf_int_ack <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("ovf_irq", {7'h00, ovf_irq}, 8'h00);
    rchk(8'h35, 8'h01, 8'h00);
    $display("overflow test done");
    end_sim;
  end
  // Whole run needs under two hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    end_sim;
  end
endmodule
bind timer_compare_core timer_compare_core_properties #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) chk_u (
  .sys_clk, .arst_n, .reg_addr, .reg_io_space, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .port_dir_out, .ovf_int_ack, .pin_oe, .ovf_irq, .async_prescaler_reset_req,
  .sync_prescaler_reset_req, .wave_mode);
